//--- rtl/serial_port_pkg.sv
/*
 constants for the serial expansion port error and interrupt block.
 assumes one 20 MHz core clock; control and status travel as plain ports.
*/
// Function
// - master with select low is mode fault
// - fault clears master select bit
// - fault clears system enable bit
// - fault sets fault flag, one fault pulse
// - fault disables all serial output drivers
// - compat: fault flag cleared by status read, control write
// - dma: fault flag cleared by writing one
// - busy data write sets collision, data dropped
// - collision detected as master and slave
// - dma slave: error pulse per mask selection
// - slave: unread byte plus new byte sets overrun
// - overrun overwrites data with new byte
// - compat: fault and done pulses, rx/tx idle
// - dma: fault pulse on fault flag rise
// - dma: done sets rx and tx complete together
// - rx complete pulses rx irq, cleared read/one
// - tx complete pulses tx irq, cleared write/one
// - four separate interrupt outputs per port
// - master data write starts a byte transfer
// - dma: collision flag cleared only by one
// - dma: overrun flag cleared only by one
package serial_port_pkg;
	// status byte layout
	localparam int STAT_DONE_BIT  = 7;
	localparam int STAT_WCOL_BIT  = 6;
	localparam int STAT_OVR_BIT   = 5;
	localparam int STAT_FAULT_BIT = 4;
	localparam int STAT_RXC_BIT   = 3;
	localparam int STAT_TXC_BIT   = 2;
	localparam int STAT_MASK_BIT  = 1;
	localparam int STAT_DMA_BIT   = 0;
	// control byte layout
	localparam int CTRL_EN_BIT    = 6;
	localparam int CTRL_MSTR_BIT  = 4;
	// reset values
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic       CTRL_RESET = 1'b0;
	// serial timing
	localparam int CLK_HZ         = 20_000_000;
	localparam int BIT_RATE_HZ    = 1_000_000;
	localparam int HALF_BIT_CYC   = CLK_HZ / (2 * BIT_RATE_HZ);
	localparam logic [7:0] HALF_BIT_LAST = 8'(HALF_BIT_CYC - 1);
	localparam logic [2:0] LAST_BIT = 3'h7;
	typedef enum logic [0:0] {XFER_IDLE, XFER_RUN} xfer_e;
endpackage : serial_port_pkg

//--- rtl/serial_port_err_irq.sv
/*
 serial expansion port core with error detection and four interrupt pulses.
 assumes pins are asynchronous and pass two flip-flops; only the
 clock-phase-0, idle-low format is shifted, msb first.
*/
`timescale 1ns/1ps
module serial_port_err_irq
(
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	input  wire logic       ctrlWrite,
	input  wire logic [7:0] ctrlWrData,
	input  wire logic       statusRead,
	input  wire logic       statusWrite,
	input  wire logic [7:0] statusWrData,
	input  wire logic       dataRead,
	input  wire logic       dataWrite,
	input  wire logic [7:0] dataWrData,
	output logic      [7:0] dataRdData,
	output logic      [7:0] statusRdData,
	output logic            masterSelect,
	output logic            systemEnable,
	input  wire logic       slaveSelIn_n,
	input  wire logic       sclkIn,
	output logic            sclkOut,
	output logic            sclkOe,
	input  wire logic       mosiIn,
	output logic            mosiOut,
	output logic            mosiOe,
	input  wire logic       misoIn,
	output logic            misoOut,
	output logic            misoOe,
	output logic            faultIrq,
	output logic            errorIrq,
	output logic            rxIrq,
	output logic            txIrq
);
	logic [3:0] syncA_q;
	logic [3:0] syncB_q;
	logic       ssLow;
	logic       sclkSync;
	logic       mosiSync;
	logic       misoSync;
	logic       sclkPrev_q;
	logic       mstr_q;
	logic       en_q;
	logic       dma_q;
	logic       mask_q;
	logic       done_q;
	logic       wcol_q;
	logic       ovr_q;
	logic       fault_q;
	logic       rxc_q;
	logic       txc_q;
	logic       armDone_q;
	logic       armWcol_q;
	logic       armOvr_q;
	logic       armFault_q;
	typedef serial_port_pkg::xfer_e xfer_e_t;
	logic [5:0] prev_q;
	xfer_e_t    state_q;
	logic [7:0] shift_q;
	logic [7:0] rxData_q;
	logic       rxBit_q;
	logic [2:0] bitCnt_q;
	logic [7:0] baud_q;
	logic       sclkGen_q;
	logic       xferDone;
	logic       faultEv;
	logic       busy;
	logic       wrAccept;
	logic       collide;
	logic       overrun;
	logic       dataAccess;
	logic       w1cWcol;
	logic       w1cOvr;
	logic       w1cFault;
	logic       w1cRxc;
	logic       w1cTxc;
	logic       clrCompat;
	logic       faultClrCompat;
	logic       tick;
	logic       sclkRise;
	logic       sclkFall;
	logic       rxPending;

	// two-stage pin synchronisers
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			syncA_q <= 4'h8;
			syncB_q <= 4'h8;
		end
		else
		begin
			syncA_q <= {slaveSelIn_n, sclkIn, mosiIn, misoIn};
			syncB_q <= syncA_q;
		end
	end

	assign ssLow    = ~syncB_q[3];
	assign sclkSync = syncB_q[2];
	assign mosiSync = syncB_q[1];
	assign misoSync = syncB_q[0];

	assign faultEv  = mstr_q & en_q & ssLow;
	assign busy     = (state_q == serial_port_pkg::XFER_RUN);
	assign wrAccept = dataWrite & en_q & ~busy;
	assign collide  = dataWrite & en_q & busy;
	assign dataAccess = (dataRead | dataWrite) & en_q;
	assign clrCompat  = ~dma_q & dataAccess;
	assign faultClrCompat = ~dma_q & armFault_q & ctrlWrite;
	assign w1cWcol  = dma_q & statusWrite & statusWrData[serial_port_pkg::STAT_WCOL_BIT];
	assign w1cOvr   = dma_q & statusWrite & statusWrData[serial_port_pkg::STAT_OVR_BIT];
	assign w1cFault = dma_q & statusWrite & statusWrData[serial_port_pkg::STAT_FAULT_BIT];
	assign w1cRxc   = dma_q & statusWrite & statusWrData[serial_port_pkg::STAT_RXC_BIT];
	assign w1cTxc   = dma_q & statusWrite & statusWrData[serial_port_pkg::STAT_TXC_BIT];
	assign rxPending = dma_q ? rxc_q : done_q;
	assign overrun  = xferDone & ~mstr_q & rxPending;
	assign tick     = (baud_q == serial_port_pkg::HALF_BIT_LAST);
	assign sclkRise = sclkSync & ~sclkPrev_q;
	assign sclkFall = ~sclkSync & sclkPrev_q;

	// control bits, forced off by a mode fault
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			mstr_q <= serial_port_pkg::CTRL_RESET;
			en_q   <= serial_port_pkg::CTRL_RESET;
		end
		else if (faultEv)
		begin
			mstr_q <= 1'b0;
			en_q   <= 1'b0;
		end
		else if (ctrlWrite)
		begin
			mstr_q <= ctrlWrData[serial_port_pkg::CTRL_MSTR_BIT];
			en_q   <= ctrlWrData[serial_port_pkg::CTRL_EN_BIT];
		end
	end

	// mode select and mask
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			dma_q  <= 1'b0;
			mask_q <= 1'b0;
		end
		else if (statusWrite)
		begin
			dma_q  <= statusWrData[serial_port_pkg::STAT_DMA_BIT];
			mask_q <= statusWrData[serial_port_pkg::STAT_MASK_BIT] & dma_q;
		end
	end

	// status read arms the compatibility clears
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			armDone_q  <= 1'b0;
			armWcol_q  <= 1'b0;
			armOvr_q   <= 1'b0;
			armFault_q <= 1'b0;
		end
		else
		begin
			if (statusRead)
			begin
				armDone_q  <= done_q;
				armWcol_q  <= wcol_q;
				armOvr_q   <= ovr_q;
				armFault_q <= fault_q;
			end
			else
			begin
				if (clrCompat)
				begin
					armDone_q <= 1'b0;
					armWcol_q <= 1'b0;
					armOvr_q  <= 1'b0;
				end
				if (ctrlWrite)
					armFault_q <= 1'b0;
			end
		end
	end

	// error flags; a new event wins over a clear
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wcol_q  <= 1'b0;
			ovr_q   <= 1'b0;
			fault_q <= 1'b0;
		end
		else
		begin
			wcol_q  <= collide | (wcol_q & ~w1cWcol & ~(clrCompat & armWcol_q));
			ovr_q   <= overrun | (ovr_q & ~w1cOvr & ~(clrCompat & armOvr_q)
				& ~(~dma_q & mstr_q));
			fault_q <= faultEv | (fault_q & ~w1cFault & ~faultClrCompat);
		end
	end

	// completion flags
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			done_q <= 1'b0;
			rxc_q  <= 1'b0;
			txc_q  <= 1'b0;
		end
		else
		begin
			done_q <= (xferDone & ~dma_q) | (done_q & ~dma_q & ~(clrCompat & armDone_q));
			rxc_q  <= (xferDone & dma_q)
				| (rxc_q & dma_q & ~w1cRxc & ~(dataRead & en_q));
			txc_q  <= (xferDone & dma_q)
				| (txc_q & dma_q & ~w1cTxc & ~(dataWrite & en_q));
		end
	end

	// link clock edge finder
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			sclkPrev_q <= 1'b0;
		else
			sclkPrev_q <= sclkSync;
	end

	// half-bit divider for master clock
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			baud_q <= 8'h00;
		else if (!busy || tick)
			baud_q <= 8'h00;
		else
			baud_q <= baud_q + 8'h01;
	end

	// byte shifter, master and slave
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_q   <= serial_port_pkg::XFER_IDLE;
			shift_q   <= serial_port_pkg::DATA_RESET;
			rxBit_q   <= 1'b0;
			bitCnt_q  <= 3'h0;
			sclkGen_q <= 1'b0;
			xferDone  <= 1'b0;
		end
		else
		begin
			xferDone <= 1'b0;
			case (state_q)
				serial_port_pkg::XFER_IDLE:
				begin
					sclkGen_q <= 1'b0;
					bitCnt_q  <= 3'h0;
					if (wrAccept)
					begin
						shift_q <= dataWrData;
						if (mstr_q)
							state_q <= serial_port_pkg::XFER_RUN;
					end
					else if (en_q && !mstr_q && ssLow && sclkRise)
					begin
						rxBit_q <= mosiSync;
						state_q <= serial_port_pkg::XFER_RUN;
					end
				end
				serial_port_pkg::XFER_RUN:
				begin
					if (faultEv || !en_q)
						state_q <= serial_port_pkg::XFER_IDLE;
					else if (mstr_q)
					begin
						if (tick)
						begin
							sclkGen_q <= ~sclkGen_q;
							if (!sclkGen_q)
								rxBit_q <= misoSync;
							else
							begin
								shift_q  <= {shift_q[6:0], rxBit_q};
								bitCnt_q <= bitCnt_q + 3'h1;
								if (bitCnt_q == serial_port_pkg::LAST_BIT)
								begin
									xferDone <= 1'b1;
									state_q  <= serial_port_pkg::XFER_IDLE;
								end
							end
						end
					end
					else if (!ssLow)
						state_q <= serial_port_pkg::XFER_IDLE;
					else if (sclkRise)
						rxBit_q <= mosiSync;
					else if (sclkFall)
					begin
						shift_q  <= {shift_q[6:0], rxBit_q};
						bitCnt_q <= bitCnt_q + 3'h1;
						if (bitCnt_q == serial_port_pkg::LAST_BIT)
						begin
							xferDone <= 1'b1;
							state_q  <= serial_port_pkg::XFER_IDLE;
						end
					end
				end
				default:
					state_q <= serial_port_pkg::XFER_IDLE;
			endcase
		end
	end

	// received byte, always replaced on completion
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			rxData_q <= serial_port_pkg::DATA_RESET;
		else if (xferDone)
			rxData_q <= shift_q;
	end

	// pin drivers, dropped at once on a fault
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sclkOe  <= 1'b0;
			mosiOe  <= 1'b0;
			misoOe  <= 1'b0;
			sclkOut <= 1'b0;
			mosiOut <= 1'b0;
			misoOut <= 1'b0;
		end
		else
		begin
			sclkOe  <= en_q & mstr_q & ~faultEv;
			mosiOe  <= en_q & mstr_q & ~faultEv;
			misoOe  <= en_q & ~mstr_q & ssLow & ~faultEv;
			sclkOut <= sclkGen_q;
			mosiOut <= shift_q[7];
			misoOut <= shift_q[7];
		end
	end

	// register views
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			dataRdData   <= 8'h00;
			statusRdData <= 8'h00;
			masterSelect <= 1'b0;
			systemEnable <= 1'b0;
		end
		else
		begin
			dataRdData   <= en_q ? rxData_q : 8'h00;
			statusRdData <= {done_q & ~dma_q, wcol_q, ovr_q, fault_q,
				rxc_q, txc_q, mask_q, dma_q};
			masterSelect <= mstr_q & ~faultEv;
			systemEnable <= en_q & ~faultEv;
		end
	end

	// flag history for edge pulses
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			prev_q <= 6'h00;
		else
			prev_q <= {fault_q, done_q, wcol_q, ovr_q, rxc_q, txc_q};
	end

	// four interrupt pulses
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			faultIrq <= 1'b0;
			errorIrq <= 1'b0;
			rxIrq    <= 1'b0;
			txIrq    <= 1'b0;
		end
		else
		begin
			faultIrq <= fault_q & ~prev_q[5];
			errorIrq <= dma_q
				? (~mstr_q & (mask_q ? (ovr_q & ~prev_q[2])
					: (wcol_q & ~prev_q[3])))
				: (done_q & ~prev_q[4]);
			rxIrq    <= dma_q & rxc_q & ~prev_q[1];
			txIrq    <= dma_q & txc_q & ~prev_q[0];
		end
	end
endmodule : serial_port_err_irq

//--- verification/serial_port_err_irq_properties.sv
/*
 assertions on the serial port error and interrupt block.
 assumes a bind onto serial_port_err_irq and one core clock.
*/
`timescale 1ns/1ps
module serial_port_err_irq_properties
(
	input wire logic       core_clk,
	input wire logic       sys_rst,
	input wire logic       dataWrite,
	input wire logic [7:0] statusRdData,
	input wire logic       masterSelect,
	input wire logic       systemEnable,
	input wire logic       slaveSelIn_n,
	input wire logic       sclkOe,
	input wire logic       mosiOe,
	input wire logic       misoOe,
	input wire logic       faultIrq,
	input wire logic       errorIrq,
	input wire logic       rxIrq,
	input wire logic       txIrq
);
	localparam int FL = serial_port_pkg::STAT_FAULT_BIT;
	localparam int WC = serial_port_pkg::STAT_WCOL_BIT;
	localparam int RX = serial_port_pkg::STAT_RXC_BIT;
	localparam int TX = serial_port_pkg::STAT_TXC_BIT;
	localparam int DM = serial_port_pkg::STAT_DMA_BIT;
	logic [3:0] irqQ;
	logic [3:0] dwQ;
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// recent interrupt and data write history
	always_ff @(posedge core_clk or posedge sys_rst)
		if (sys_rst)
		begin
			irqQ <= 4'h0;
			dwQ  <= 4'h0;
		end
		else
		begin
			irqQ <= {faultIrq, errorIrq, rxIrq, txIrq};
			dwQ  <= {dwQ[2:0], dataWrite};
		end
	property p_mstr_clr;
		$fell(slaveSelIn_n) && masterSelect |-> ##[1:4] !masterSelect;
	endproperty
	a_mstr_clr: assert property (p_mstr_clr) else $error("master kept");
	property p_en_clr;
		$fell(slaveSelIn_n) && masterSelect |-> ##[1:4] !systemEnable;
	endproperty
	a_en_clr: assert property (p_en_clr) else $error("enable kept");
	property p_oe_off;
		$fell(systemEnable) |-> !sclkOe && !mosiOe && !misoOe;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("driver on");
	property p_flt_irq;
		$rose(statusRdData[FL]) |-> ##[0:3] faultIrq;
	endproperty
	a_flt_irq: assert property (p_flt_irq) else $error("no fault pulse");
	property p_pulse;
		({faultIrq, errorIrq, rxIrq, txIrq} & irqQ) == 4'h0;
	endproperty
	a_pulse: assert property (p_pulse) else $error("long pulse");
	property p_quiet;
		!statusRdData[DM] [*4] |-> !rxIrq && !txIrq;
	endproperty
	a_quiet: assert property (p_quiet) else $error("rx or tx pulse");
	property p_both;
		$rose(statusRdData[RX]) && masterSelect |-> statusRdData[TX];
	endproperty
	a_both: assert property (p_both) else $error("split done");
	property p_wcol;
		$rose(statusRdData[WC]) |-> dwQ != 4'h0;
	endproperty
	a_wcol: assert property (p_wcol) else $error("stray collision");
	property p_rx_irq;
		$rose(statusRdData[RX]) |-> rxIrq;
	endproperty
	a_rx_irq: assert property (p_rx_irq) else $error("no rx pulse");
	property p_tx_irq;
		$rose(statusRdData[TX]) |-> txIrq;
	endproperty
	a_tx_irq: assert property (p_tx_irq) else $error("no tx pulse");
endmodule : serial_port_err_irq_properties
bind serial_port_err_irq serial_port_err_irq_properties serial_port_err_irq_properties_i
(
	.core_clk(core_clk),
	.sys_rst(sys_rst),
	.dataWrite(dataWrite),
	.statusRdData(statusRdData),
	.masterSelect(masterSelect),
	.systemEnable(systemEnable),
	.slaveSelIn_n(slaveSelIn_n),
	.sclkOe(sclkOe),
	.mosiOe(mosiOe),
	.misoOe(misoOe),
	.faultIrq(faultIrq),
	.errorIrq(errorIrq),
	.rxIrq(rxIrq),
	.txIrq(txIrq)
);

//--- verification/remote_port_model.sv
/*
 remote serial device acting as master or slave.
 assumes idle-low clock, sample on rise, msb first.
*/
`timescale 1ns/1ps
module remote_port_model
(
	input  wire logic       sclkLine,
	input  wire logic       mosiLine,
	input  wire logic       misoLine,
	output logic            mSclk,
	output logic            mMosi,
	output logic            mMiso,
	output logic            ssN,
	output logic [7:0]      rxByte
);
	logic [7:0] sh = 8'h00;
	initial
	begin
		mSclk = 1'b0;
		mMosi = 1'b0;
		ssN = 1'b1;
		rxByte = 8'h00;
	end
	assign mMiso = sh[7];
	always @(negedge sclkLine)
		sh <= {sh[6:0], ~sh[0]};
	always @(posedge sclkLine)
		rxByte <= {rxByte[6:0], ssN ? mosiLine : misoLine};
	task automatic send(input logic [7:0] b);
		ssN = 1'b0;
		for (int i = 7; i >= 0; i--)
		begin
			mMosi = b[i];
			#200 mSclk = 1'b1;
			#200 mSclk = 1'b0;
		end
		mMosi = ~b[0];
		#200 ssN = 1'b1;
	endtask : send
	task automatic fault;
		#100 ssN = 1'b0;
		#500 ssN = 1'b1;
	endtask : fault
endmodule : remote_port_model

//--- verification/test_serial_port_err_irq.sv
/*
 testbench for the serial port error and interrupt block.
 assumes the remote port model on the pins.
*/
`timescale 1ns/1ps
module test_serial_port_err_irq;
	localparam int DN = serial_port_pkg::STAT_DONE_BIT;
	localparam int WC = serial_port_pkg::STAT_WCOL_BIT;
	localparam int OV = serial_port_pkg::STAT_OVR_BIT;
	localparam int FL = serial_port_pkg::STAT_FAULT_BIT;
	localparam int RX = serial_port_pkg::STAT_RXC_BIT;
	localparam int TX = serial_port_pkg::STAT_TXC_BIT;
	logic       core_clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic [4:0] stb = 5'h00;
	logic [7:0] wd = 8'h00;
	logic [7:0] rdD, st, rxB;
	logic [3:0] irq;
	logic       ms, en, sclkO, sclkE, mosiO, mosiE, misoO, misoE;
	logic       mSclk, mMosi, mMiso, ssN;
	logic [7:0] cnt [4] = '{default: 8'h00};
	int         errorCnt = 0;
	int         checksDone = 0;
	initial forever #25 core_clk = ~core_clk;
	always @(posedge core_clk)
		for (int i = 0; i < 4; i++)
			cnt[i] <= cnt[i] + {7'h00, irq[i]};
	serial_port_err_irq serial_port_err_irq_i
	(
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.ctrlWrite(stb[0]),
		.ctrlWrData(wd),
		.statusRead(stb[1]),
		.statusWrite(stb[2]),
		.statusWrData(wd),
		.dataRead(stb[3]),
		.dataWrite(stb[4]),
		.dataWrData(wd),
		.dataRdData(rdD),
		.statusRdData(st),
		.masterSelect(ms),
		.systemEnable(en),
		.slaveSelIn_n(ssN),
		.sclkIn(sclkE ? sclkO : mSclk),
		.sclkOut(sclkO),
		.sclkOe(sclkE),
		.mosiIn(mosiE ? mosiO : mMosi),
		.mosiOut(mosiO),
		.mosiOe(mosiE),
		.misoIn(misoE ? misoO : mMiso),
		.misoOut(misoO),
		.misoOe(misoE),
		.faultIrq(irq[3]),
		.errorIrq(irq[2]),
		.rxIrq(irq[1]),
		.txIrq(irq[0])
	);
	remote_port_model remote_port_model_i
	(
		.sclkLine(sclkE ? sclkO : mSclk),
		.mosiLine(mosiE ? mosiO : mMosi),
		.misoLine(misoE ? misoO : mMiso),
		.mSclk(mSclk),
		.mMosi(mMosi),
		.mMiso(mMiso),
		.ssN(ssN),
		.rxByte(rxB)
	);
	task automatic closeOut;
		$display("checks %0d errors %0d", checksDone, errorCnt);
		if (errorCnt == 0 && checksDone > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : closeOut
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checksDone++;
		if (g !== e)
		begin
			errorCnt++;
			$display("Error at %0t ns: got %h expected %h", $time, g, e);
		end
	endtask : chk
	// one-cycle strobe: 0 ctrl write, 1 status read, 2 status write, 3 data read, 4 data write
	task automatic acc(input int k, input logic [7:0] v);
		@(posedge core_clk);
		stb <= 5'h01 << k;
		wd <= v;
		@(posedge core_clk);
		stb <= 5'h00;
	endtask : acc
	task automatic settle;
		repeat (4) @(negedge core_clk);
	endtask : settle
	task automatic waitBit(input int b);
		int n = 0;
		while (st[b] !== 1'b1 && n < 600)
		begin
			@(negedge core_clk);
			n++;
		end
		if (n == 600)
		begin
			errorCnt++;
			closeOut;
		end
		settle;
	endtask : waitBit
	initial
	begin
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		settle;
		chk(st, 8'h00);
		chk({rdD[3:0], ms, en, sclkE, irq[3]}, 8'h00);
		remote_port_model_i.sh = 8'h96;
		acc(0, 8'h50);
		acc(4, 8'hC3);
		waitBit(DN);
		chk(rxB, 8'hC3);
		chk(rdD, 8'h96);
		chk(cnt[2], 8'h01);
		chk(cnt[1] | cnt[0], 8'h00);
		acc(1, 8'h00);
		acc(3, 8'h00);
		acc(4, 8'h11);
		repeat (30) @(posedge core_clk);
		acc(4, 8'hEE);
		waitBit(DN);
		chk(rxB, 8'h11);
		chk(8'(st[WC]), 8'h01);
		chk(cnt[2], 8'h02);
		acc(1, 8'h00);
		acc(3, 8'h00);
		remote_port_model_i.fault();
		settle;
		chk({2'h0, ms, en, sclkE, mosiE, misoE, st[FL]}, 8'h01);
		chk(cnt[3], 8'h01);
		acc(0, 8'h00);
		settle;
		chk(8'(st[FL]), 8'h01);
		acc(1, 8'h00);
		acc(0, 8'h00);
		settle;
		chk(8'(st[FL]), 8'h00);
		acc(2, 8'h01);
		acc(0, 8'h50);
		acc(4, 8'h5A);
		waitBit(RX);
		chk({6'h00, st[RX], st[TX]}, 8'h03);
		chk({cnt[1][3:0], cnt[0][3:0]}, 8'h11);
		acc(3, 8'h00);
		settle;
		chk({6'h00, st[RX], st[TX]}, 8'h01);
		acc(4, 8'h77);
		settle;
		chk(8'(st[TX]), 8'h00);
		waitBit(RX);
		acc(2, 8'h01);
		settle;
		chk({6'h00, st[RX], st[TX]}, 8'h03);
		acc(2, 8'h0D);
		settle;
		chk({6'h00, st[RX], st[TX]}, 8'h00);
		remote_port_model_i.fault();
		settle;
		chk(cnt[3], 8'h02);
		acc(2, 8'h01);
		settle;
		chk(8'(st[FL]), 8'h01);
		acc(2, 8'h11);
		settle;
		chk(8'(st[FL]), 8'h00);
		acc(0, 8'h40);
		remote_port_model_i.send(8'h3C);
		remote_port_model_i.send(8'h7E);
		settle;
		chk(8'(st[OV]), 8'h01);
		chk(rdD, 8'h7E);
		chk(cnt[2], 8'h02);
		fork
			remote_port_model_i.send(8'h81);
			begin
				#1000;
				acc(4, 8'h99);
			end
		join
		settle;
		chk(8'(st[WC]), 8'h01);
		chk(cnt[2], 8'h03);
		acc(2, 8'h01);
		settle;
		chk({6'h00, st[WC], st[OV]}, 8'h03);
		acc(2, 8'h61);
		settle;
		chk({6'h00, st[WC], st[OV]}, 8'h00);
		acc(2, 8'h03);
		remote_port_model_i.send(8'h42);
		settle;
		chk(cnt[2], 8'h04);
		closeOut;
	end
endmodule : test_serial_port_err_irq
